// >>> logic/channel_offset_register_bank.sv
`timescale 1ns/10ps
module channel_offset_register_bank
   import offset_bank_pkg::*;
(
   input  wire logic        ref_clk,      // 20 MHz clock
   input  wire logic        rst_n,        // Synchronous reset, active low
   input  wire logic        psel,         // APB select
   input  wire logic        penable,      // APB access phase
   input  wire logic        pwrite,       // APB write
   input  wire logic [11:0] paddr,        // APB byte address
   input  wire logic [31:0] pwdata,       // APB write data
   output logic [31:0]      prdata,       // APB read data
   output logic             pready,       // APB ready
   output logic             pslverr,      // APB error on unmapped address
   input  wire logic        pixel_even,   // Current pixel is even
   output rgb_offset_t      active_offset, // Offsets applied to the channels
   output logic             alternate_pixel_offset_mode // Mode bit state
);
   typedef struct packed {
      logic [NUM_OFS-1:0][9:0] ofs;
      logic [9:0]              mode;
      logic                    soft_reset;
      logic [31:0]             rdata;
      logic                    err;
      rgb_offset_t             out;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic       aligned;
   logic [4:0] index;
   logic       is_offset;
   logic [3:0] slot;
   logic       access;
   logic       mapped;
   logic       use_even;
   logic       rd_setup;
   logic       reset_req;

   offset_apb_decode u_dec (
      .paddr     (paddr),
      .aligned   (aligned),
      .index     (index),
      .is_offset (is_offset),
      .slot      (slot)
   );

   function automatic logic [9:0] slot_reset(input int s);
      return SLOT_IS_FINE[s] ? FINE_RESET : COARSE_RESET;
   endfunction

   // Register hit on an aligned word; shared by write, read mux and checks
   function automatic logic hits(input logic al, input logic [4:0] idx,
                                 input logic [4:0] target);
      return al && (idx == target);
   endfunction

   assign access = psel && penable;
   assign rd_setup = psel && !penable && !pwrite;
   assign reset_req = access && pwrite && hits(aligned, index, IDX_CONTROL)
                      && pwdata[CTRL_RESET_BIT];
   assign mapped = is_offset || hits(aligned, index, IDX_CONTROL)
                   || hits(aligned, index, IDX_MODE);
   assign pready = 1'b1;
   assign prdata = cur.rdata;
   assign pslverr = access && !mapped;
   assign alternate_pixel_offset_mode = cur.mode[MODE_ALT_BIT];
   assign active_offset = cur.out;
   assign use_even = cur.mode[MODE_ALT_BIT] && pixel_even;

   always_comb begin
      next_cur = cur;
      next_cur.err = access && !mapped;
      next_cur.soft_reset = 1'b0;
      if (access && pwrite) begin
         if (is_offset)
            next_cur.ofs[slot] = pwdata[9:0];
         else if (hits(aligned, index, IDX_MODE))
            next_cur.mode = pwdata[9:0];
         else if (reset_req)
            next_cur.soft_reset = 1'b1;
      end
      if (cur.soft_reset) begin
         // Whole register set returns to defaults, pulse self-clears
         for (int s = 0; s < NUM_OFS; s++)
            next_cur.ofs[s] = slot_reset(s);
         next_cur.mode = MODE_RESET;
      end
      // Read word fetched in setup so it already stands while pready is high;
      // taken after the soft reset so a read right behind it sees defaults
      if (rd_setup) begin
         next_cur.rdata = 32'h0000_0000;
         if (is_offset)
            next_cur.rdata[9:0] = next_cur.ofs[slot];
         else if (hits(aligned, index, IDX_MODE))
            next_cur.rdata[9:0] = next_cur.mode;
         else if (hits(aligned, index, IDX_CONTROL))
            next_cur.rdata[CTRL_RESET_BIT] = next_cur.soft_reset;
      end
      // Primary set: slots 0..4 = gc, bc, rf, gf, bf; red coarse not held here
      next_cur.out.red.coarse   = use_even ? cur.ofs[5] : COARSE_RESET;
      next_cur.out.green.coarse = use_even ? cur.ofs[6] : cur.ofs[0];
      next_cur.out.blue.coarse  = use_even ? cur.ofs[7] : cur.ofs[1];
      next_cur.out.red.fine     = use_even ? cur.ofs[8] : cur.ofs[2];
      next_cur.out.green.fine   = use_even ? cur.ofs[9] : cur.ofs[3];
      // No even blue fine register held here; primary blue fine applies
      next_cur.out.blue.fine    = cur.ofs[4];
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int s = 0; s < NUM_OFS; s++)
            cur.ofs[s] <= slot_reset(s);
         cur.mode       <= MODE_RESET;
         cur.soft_reset <= 1'b0;
         cur.rdata      <= 32'h0000_0000;
         cur.err        <= 1'b0;
         cur.out.red    <= {COARSE_RESET, FINE_RESET};
         cur.out.green  <= {COARSE_RESET, FINE_RESET};
         cur.out.blue   <= {COARSE_RESET, FINE_RESET};
      end else begin
         cur <= next_cur;
      end
   end

   property p_ofs_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && pwrite && is_offset && !cur.soft_reset)
         |=> (cur.ofs[$past(slot)] == $past(pwdata[9:0]));
   endproperty
   a_ofs_write: assert property (p_ofs_write) else $error("offset write lost");

   property p_soft_reset_coarse;
      @(posedge ref_clk) disable iff (!rst_n)
      (cur.soft_reset && !(access && pwrite)) |=> (cur.ofs[0] == COARSE_RESET
         && cur.ofs[1] == COARSE_RESET && cur.ofs[7] == COARSE_RESET);
   endproperty
   a_soft_reset_coarse: assert property (p_soft_reset_coarse) else $error("coarse default");

   property p_soft_reset_fine;
      @(posedge ref_clk) disable iff (!rst_n)
      (cur.soft_reset && !(access && pwrite)) |=> (cur.ofs[2] == FINE_RESET
         && cur.ofs[9] == FINE_RESET && cur.mode == MODE_RESET);
   endproperty
   a_soft_reset_fine: assert property (p_soft_reset_fine) else $error("fine default");

   sequence s_reset_req;
      reset_req;
   endsequence
   // A second request during the pulse legally stretches it
   sequence s_pulse_then_clear;
      cur.soft_reset ##1 (!cur.soft_reset || $past(reset_req));
   endsequence
   property p_self_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reset_req |=> s_pulse_then_clear;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("reset bit stuck");

   property p_even_sel;
      @(posedge ref_clk) disable iff (!rst_n)
      (cur.mode[MODE_ALT_BIT] && pixel_even) |=> (cur.out.green.coarse == $past(cur.ofs[6])
         && cur.out.red.fine == $past(cur.ofs[8]));
   endproperty
   a_even_sel: assert property (p_even_sel) else $error("even set not applied");

   property p_odd_sel;
      @(posedge ref_clk) disable iff (!rst_n)
      !(cur.mode[MODE_ALT_BIT] && pixel_even) |=> (cur.out.blue.coarse == $past(cur.ofs[1])
         && cur.out.green.fine == $past(cur.ofs[3]));
   endproperty
   a_odd_sel: assert property (p_odd_sel) else $error("primary set not applied");

   property p_mode_bit;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && pwrite && aligned && index == IDX_MODE && !cur.soft_reset)
         |=> alternate_pixel_offset_mode == $past(pwdata[MODE_ALT_BIT]);
   endproperty
   a_mode_bit: assert property (p_mode_bit) else $error("mode bit not stored");

   property p_read_back;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && !pwrite && is_offset) |-> prdata == {22'h0, cur.ofs[slot]};
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data wrong");

   property p_read_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && !pwrite && hits(aligned, index, IDX_MODE)) |-> prdata == {22'h0, cur.mode};
   endproperty
   a_read_mode: assert property (p_read_mode) else $error("mode read wrong");

   property p_read_control;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && !pwrite && hits(aligned, index, IDX_CONTROL)) |-> prdata == 32'h0000_0000;
   endproperty
   a_read_control: assert property (p_read_control) else $error("reset bit seen set");

   property p_upper_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && !pwrite) |-> prdata[31:10] == 22'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

   // Read word must not move between reads
   property p_rdata_stands;
      @(posedge ref_clk) disable iff (!rst_n)
      !rd_setup |=> $stable(prdata);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");

   // Unmapped or unaligned access leaves every register untouched
   property p_refused;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && !mapped && !cur.soft_reset)
         |=> (cur.err && $stable(cur.ofs) && $stable(cur.mode));
   endproperty
   a_refused: assert property (p_refused) else $error("refused access changed state");

   property p_err_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      !(access && !mapped) |=> !cur.err;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error flag stuck");

   // Without a write or soft reset nothing may drift
   property p_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (!(access && pwrite) && !cur.soft_reset)
         |=> ($stable(cur.ofs) && $stable(cur.mode));
   endproperty
   a_hold: assert property (p_hold) else $error("register drifted");

   // Control write without the reset bit must do nothing at all
   property p_control_plain;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && pwrite && hits(aligned, index, IDX_CONTROL) && !reset_req && !cur.soft_reset)
         |=> ($stable(cur.ofs) && !cur.soft_reset);
   endproperty
   a_control_plain: assert property (p_control_plain) else $error("control write acted");

   // No disable here: this one checks the reset branch itself
   property p_hw_reset;
      @(posedge ref_clk)
      !rst_n |=> (cur.mode == MODE_RESET && !cur.soft_reset && !cur.err
         && cur.rdata == 32'h0000_0000 && cur.out.red == {COARSE_RESET, FINE_RESET}
         && cur.out.green == {COARSE_RESET, FINE_RESET}
         && cur.out.blue == {COARSE_RESET, FINE_RESET});
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("reset state wrong");

   // Every slot: hardware reset and soft reset both land on its default
   for (genvar g = 0; g < NUM_OFS; g++) begin : g_slot
      property p_slot_default;
         @(posedge ref_clk)
         (!rst_n || cur.soft_reset) |=> cur.ofs[g] == slot_reset(g);
      endproperty
      a_slot_default: assert property (p_slot_default) else $error("slot default");
   end

   property p_mode_full;
      @(posedge ref_clk) disable iff (!rst_n)
      (access && pwrite && hits(aligned, index, IDX_MODE) && !cur.soft_reset)
         |=> cur.mode == $past(pwdata[9:0]);
   endproperty
   a_mode_full: assert property (p_mode_full) else $error("mode word not stored");

   property p_even_rest;
      @(posedge ref_clk) disable iff (!rst_n)
      use_even |=> (cur.out.red.coarse == $past(cur.ofs[5])
         && cur.out.blue.coarse == $past(cur.ofs[7]) && cur.out.green.fine == $past(cur.ofs[9]));
   endproperty
   a_even_rest: assert property (p_even_rest) else $error("even set incomplete");

   property p_odd_rest;
      @(posedge ref_clk) disable iff (!rst_n)
      !use_even |=> (cur.out.green.coarse == $past(cur.ofs[0])
         && cur.out.red.fine == $past(cur.ofs[2]) && cur.out.red.coarse == COARSE_RESET);
   endproperty
   a_odd_rest: assert property (p_odd_rest) else $error("primary set incomplete");

   property p_blue_fine;
      @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> cur.out.blue.fine == $past(cur.ofs[4]);
   endproperty
   a_blue_fine: assert property (p_blue_fine) else $error("blue fine not applied");

   // Write to output in two steps: store, then registered selection
   sequence s_green_write;
      access && pwrite && hits(aligned, index, IDX_GREEN_COARSE) && !cur.soft_reset;
   endsequence
   property p_green_reach;
      @(posedge ref_clk) disable iff (!rst_n)
      s_green_write ##1 !use_even
         |=> cur.out.green.coarse == $past(pwdata[9:0], 2);
   endproperty
   a_green_reach: assert property (p_green_reach) else $error("write not applied");

   sequence s_soft_pulse;
      cur.soft_reset;
   endsequence
   property p_soft_out;
      @(posedge ref_clk) disable iff (!rst_n)
      s_soft_pulse ##1 !use_even |=> (cur.out.green.coarse == COARSE_RESET
         && cur.out.red.fine == FINE_RESET && cur.out.blue.fine == FINE_RESET);
   endproperty
   a_soft_out: assert property (p_soft_out) else $error("outputs kept old offsets");
endmodule

// >>> logic/offset_apb_decode.sv
`timescale 1ns/10ps
module offset_apb_decode
   import offset_bank_pkg::*;
(
   input  wire logic [11:0] paddr,      // APB byte address
   output logic             aligned,    // Word aligned and inside the first 128 bytes
   output logic [4:0]       index,      // Register index
   output logic             is_offset,  // Index hits an offset slot
   output logic [3:0]       slot        // Offset slot number
);
   logic [4:0] diff;
   always_comb begin
      aligned   = (paddr[1:0] == 2'b00) && (paddr[11:7] == 5'h00);
      index     = paddr[6:2];
      diff      = index - IDX_GREEN_COARSE;
      is_offset = aligned && (index >= IDX_GREEN_COARSE) && (index <= IDX_EVEN_GREEN_FINE);
      slot      = diff[3:0];
   end
endmodule

// >>> logic/offset_bank_pkg.sv
package offset_bank_pkg;
   localparam int OFS_W = 10;
   // Register indices as printed; byte address is four times the index
   localparam logic [4:0] IDX_GREEN_COARSE      = 5'h04;
   localparam logic [4:0] IDX_BLUE_COARSE       = 5'h05;
   localparam logic [4:0] IDX_RED_FINE          = 5'h06;
   localparam logic [4:0] IDX_GREEN_FINE        = 5'h07;
   localparam logic [4:0] IDX_BLUE_FINE         = 5'h08;
   localparam logic [4:0] IDX_EVEN_RED_COARSE   = 5'h09;
   localparam logic [4:0] IDX_EVEN_GREEN_COARSE = 5'h0A;
   localparam logic [4:0] IDX_EVEN_BLUE_COARSE  = 5'h0B;
   localparam logic [4:0] IDX_EVEN_RED_FINE     = 5'h0C;
   localparam logic [4:0] IDX_EVEN_GREEN_FINE   = 5'h0D;
   localparam logic [4:0] IDX_CONTROL           = 5'h0F;
   localparam logic [4:0] IDX_MODE              = 5'h14;
   localparam int CTRL_RESET_BIT = 0;
   localparam int MODE_ALT_BIT   = 1;
   localparam logic [9:0] COARSE_RESET = 10'h155;
   localparam logic [9:0] FINE_RESET   = 10'h200;
   localparam logic [9:0] MODE_RESET   = 10'h001;
   localparam int NUM_OFS = 10;
   // Storage slot order, index - IDX_GREEN_COARSE
   localparam logic [NUM_OFS-1:0] SLOT_IS_FINE = 10'b11_000_11100;

   typedef struct packed {
      logic [9:0] coarse;
      logic [9:0] fine;
   } chan_offset_t;

   typedef struct packed {
      chan_offset_t red;
      chan_offset_t green;
      chan_offset_t blue;
   } rgb_offset_t;
endpackage

// >>> testbench/tb_channel_offset_register_bank.sv
`timescale 1ns/10ps
module tb_channel_offset_register_bank;
   import offset_bank_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic        pixel_even = 1'b0;
   logic [31:0] prdata, rd, v;
   logic        pready, pslverr, alt, err;
   rgb_offset_t active_offset;
   logic [9:0]  model [NUM_OFS];
   logic [31:0] seed = 32'h0000_6F9D;
   int          num_errors = 0;
   int          check_count = 0;

   channel_offset_register_bank channel_offset_register_bank_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pixel_even(pixel_even), .active_offset(active_offset),
      .alternate_pixel_offset_mode(alt));

   always #25 ref_clk = ~ref_clk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic rgb_offset_t want_ofs(input logic ev);
      rgb_offset_t w;
      // Red primary coarse lives outside this bank
      w.red.coarse   = ev ? model[5] : COARSE_RESET;
      w.red.fine     = ev ? model[8] : model[2];
      w.green.coarse = ev ? model[6] : model[0];
      w.green.fine   = ev ? model[9] : model[3];
      w.blue.coarse  = ev ? model[7] : model[1];
      w.blue.fine    = model[4];
      return w;
   endfunction

   task automatic give_verdict();
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      check_count++;
      if (seen !== want) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   // Called just after a rising edge; returns just after one
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         num_errors++;
         give_verdict();
      end else begin
         // Answer taken at the edge that sees pready, before anything moves
         err     = pslverr;
         rd      = prdata;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
      end
   endtask

   task automatic defaults();
      for (int i = 0; i < NUM_OFS; i++)
         model[i] = (i inside {2, 3, 4, 8, 9}) ? FINE_RESET : COARSE_RESET;
   endtask

   task automatic check_all();
      for (int i = 0; i < NUM_OFS; i++) begin
         apb(1'b0, 12'((i + 4) * 4), 32'h0000_0000);
         check({err, rd}, {1'b0, 22'h0, model[i]});
      end
   endtask

   // Selection is registered, so allow two edges
   task automatic see_ofs(input logic ev, input logic want_even);
      pixel_even <= ev;
      repeat (2) @(posedge ref_clk);
      #1 check(active_offset, want_ofs(want_even));
      @(posedge ref_clk);
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      defaults();
      check_all();
      apb(1'b0, 12'h050, 32'h0000_0000);
      check({alt, rd}, 33'h0_0000_0001);
      see_ofs(1'b1, 1'b0);
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < NUM_OFS; i++) begin
            v = (r == 0) ? 32'h0000_0000 : (r == 1) ? 32'hFFFF_FFFF : xs();
            apb(1'b1, 12'((i + 4) * 4), v);
            model[i] = v[9:0];
         end
         check_all();
      end
      apb(1'b1, 12'h050, 32'h0000_0003);
      apb(1'b0, 12'h050, 32'h0000_0000);
      check({alt, rd}, 33'h1_0000_0003);
      see_ofs(1'b1, 1'b1);
      see_ofs(1'b0, 1'b0);
      apb(1'b1, 12'h040, xs());
      check(err, 1'b1);
      apb(1'b0, 12'h011, 32'h0000_0000);
      check({err, rd}, 33'h1_0000_0000);
      apb(1'b1, 12'h03C, 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      defaults();
      check_all();
      apb(1'b0, 12'h050, 32'h0000_0000);
      check({alt, rd}, 33'h0_0000_0001);
      apb(1'b0, 12'h03C, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      see_ofs(1'b1, 1'b0);
      give_verdict();
   end
endmodule
